// File: src/fsr_pkg.sv
// Constants for the second flash status register block.
// Assumes a single 10 MHz clock domain and a command decoder upstream.
package fsr_pkg;
    // Opcodes seen on the command strobe
    localparam logic [7:0] OP_SUSPEND = 8'h75;
    localparam logic [7:0] OP_RESUME = 8'h7A;
    localparam logic [7:0] OP_RST_EN = 8'h66;
    localparam logic [7:0] OP_RST_DO = 8'h99;
    localparam logic [7:0] OP_QREAD = 8'h6B;
    localparam logic [7:0] OP_XIP_READ = 8'hEB;
    localparam logic [7:0] OP_XIP_WREAD = 8'hE7;
    localparam logic [7:0] OP_QPROG = 8'h32;
    localparam logic [7:0] OP_BURST_WRAP = 8'h77;
    localparam logic [7:0] OP_QID_READ = 8'h94;
    localparam logic [7:0] OP_WSR1 = 8'h01;
    localparam logic [7:0] OP_WSR2 = 8'h31;
    // Field positions in the register
    localparam int BIT_PAUSED = 7;
    localparam int BIT_INVERT = 6;
    localparam int BIT_LOCK_HI = 5;
    localparam int BIT_LOCK_LO = 3;
    localparam int BIT_RSVD = 2;
    localparam int BIT_FOUR_LINE = 1;
    localparam int BIT_MODE_UPPER = 0;
    // Writable bit mask and reset value
    localparam logic [7:0] SR2_WMASK = 8'h43;
    localparam logic [7:0] SR2_RESET = 8'h00;
    // Byte index of the last byte of a 128-byte security register
    localparam logic [6:0] SEC_LAST_BYTE = 7'h7F;
    localparam int NUM_SEC_REGS = 4;
endpackage : fsr_pkg

// File: src/fsr_lock_store.sv
// Holds the one-time lock flags of the security registers.
// Assumes program strobes come from the same clock domain.
`timescale 1ns/1ps
`default_nettype none
module fsr_lock_store
    import fsr_pkg::*;
(
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic set_valid,
    input wire logic [1:0] set_index,
    output logic [NUM_SEC_REGS-1:0] lock_q
);
    logic [NUM_SEC_REGS-1:0] flags_r;
    logic [NUM_SEC_REGS-1:0] flags_nxt;

    // Flags only ever set; index 0 is factory locked
    always_comb begin
        flags_nxt = flags_r;
        flags_nxt[0] = 1'b1;
        if (set_valid) begin
            flags_nxt[set_index] = 1'b1;
        end
    end

    // Reset models a blank part; real parts keep these in nonvolatile cells
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            flags_r <= 4'h1;
        end else begin
            flags_r <= flags_nxt;
        end
    end

    assign lock_q = flags_r;
endmodule : fsr_lock_store
`default_nettype wire

// File: src/fsr_status_two.sv
// Second status register of a serial flash: pause flag, invert,
// lock flags, four-line enable and upper lock mode bit.
// Assumes a decoder delivers whole commands as one-cycle strobes.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Suspend opcode sets paused flag
// - Resume or any reset clears paused flag
// - Invert bit swaps protected regions
// - Three lock flags in bits five-three
// - Last byte programmed sets its lock
// - Locked security register refuses programming
// - Security register zero always locked
// - Four-line enable repurposes protect, pause pins
// - Quad and execute-in-place reads need enable
// - Quad program, wrap, ID need enable
// - Mode bits plus pin select protection
// - Mode zero accepts writes with latch
// - Lockdown modes refuse writes until reset
// - Pause/reset function only without enable
module fsr_status_two
    import fsr_pkg::*;
(
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_opcode,
    input wire logic wr_valid,
    input wire logic [7:0] wr_data,
    input wire logic write_permit_latch,
    input wire logic lock_mode_lower,
    input wire logic permanent_lock_bit,
    input wire logic protect_pin_n,
    input wire logic pause_reset_sel,
    input wire logic sec_prog_valid,
    input wire logic [1:0] sec_prog_index,
    input wire logic [6:0] sec_prog_byte,
    output logic [7:0] status_two,
    output logic paused_op_flag,
    output logic protection_invert,
    output logic four_line_enable,
    output logic lock_mode_upper,
    output logic sec_prog_ok,
    output logic quad_cmd_ok,
    output logic sr_write_ok,
    output logic protect_pin_active,
    output logic pause_pin_active,
    output logic reset_pin_active
);
    typedef enum logic [1:0] {
        FSR_IDLE = 2'b00,
        FSR_RST_ARMED = 2'b01
    } fsr_rst_t;

    fsr_rst_t rst_st_r, rst_st_nxt;
    logic paused_r, paused_nxt;
    logic invert_r, invert_nxt;
    logic four_r, four_nxt;
    logic upper_r, upper_nxt;
    logic [7:0] sr_r, sr_nxt;
    logic sec_ok_r, sec_ok_nxt;
    logic quad_ok_r, quad_ok_nxt;
    logic wr_ok_r, wr_ok_nxt;
    logic prot_r, prot_nxt;
    logic pause_r, pause_nxt;
    logic rstp_r, rstp_nxt;
    logic [NUM_SEC_REGS-1:0] lock_q;
    logic soft_rst;
    logic last_byte;
    logic wr_allowed;

    // Is the opcode one that drives the extra data lines
    function automatic logic is_quad_op(input logic [7:0] op);
        is_quad_op = (op == OP_QREAD) || (op == OP_XIP_READ) || (op == OP_XIP_WREAD)
            || (op == OP_QPROG) || (op == OP_BURST_WRAP) || (op == OP_QID_READ);
    endfunction : is_quad_op

    // Flag store lives apart so its reset policy can change alone
    assign last_byte = sec_prog_valid && (sec_prog_byte == SEC_LAST_BYTE)
        && (sec_prog_index != 2'd0) && !lock_q[sec_prog_index];
    fsr_lock_store u_lock (
        .ref_clk(ref_clk),
        .srst(srst),
        .set_valid(last_byte),
        .set_index(sec_prog_index),
        .lock_q(lock_q)
    );

    // Software reset needs 66h with 99h as the next command; idle cycles in between are allowed
    assign soft_rst = cmd_valid && (cmd_opcode == OP_RST_DO) && (rst_st_r == FSR_RST_ARMED);

    // Mode decode: zero accepts, 0,1 follows pin, 1,x locks down
    assign wr_allowed = write_permit_latch && !upper_r
        && (!lock_mode_lower || protect_pin_n || four_r);

    // Next state of all register bits and qualifiers
    always_comb begin
        rst_st_nxt = rst_st_r;
        paused_nxt = paused_r;
        invert_nxt = invert_r;
        four_nxt = four_r;
        upper_nxt = upper_r;
        if (cmd_valid) begin
            rst_st_nxt = (cmd_opcode == OP_RST_EN) ? FSR_RST_ARMED : FSR_IDLE;
            if (cmd_opcode == OP_SUSPEND) begin
                paused_nxt = 1'b1;
            end
            if (cmd_opcode == OP_RESUME) begin
                paused_nxt = 1'b0;
            end
        end
        if (wr_valid && wr_allowed) begin
            invert_nxt = wr_data[BIT_INVERT];
            four_nxt = wr_data[BIT_FOUR_LINE];
            upper_nxt = wr_data[BIT_MODE_UPPER];
        end
        if (soft_rst) begin
            // Soft reset ends pause, and lockdown unless in one-time mode; keeps config
            paused_nxt = 1'b0;
            // Permanent lock with lower bit set is one-time mode: soft reset must not lift it
            if (!(lock_mode_lower && permanent_lock_bit)) begin
                upper_nxt = 1'b0;
            end
        end
        sr_nxt = {paused_nxt, invert_nxt, lock_q[3:1], 1'b0, four_nxt, upper_nxt};
        sec_ok_nxt = !lock_q[sec_prog_index];
        quad_ok_nxt = four_nxt;
        wr_ok_nxt = write_permit_latch && !upper_nxt
            && (!lock_mode_lower || protect_pin_n || four_nxt);
        prot_nxt = !four_nxt;
        pause_nxt = !four_nxt && !pause_reset_sel;
        rstp_nxt = !four_nxt && pause_reset_sel;
    end

    // Hardware reset returns every field to default
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            rst_st_r <= FSR_IDLE;
            paused_r <= 1'b0;
            invert_r <= 1'b0;
            four_r <= 1'b0;
            upper_r <= 1'b0;
            sr_r <= SR2_RESET;
            sec_ok_r <= 1'b0;
            quad_ok_r <= 1'b0;
            wr_ok_r <= 1'b0;
            prot_r <= 1'b1;
            pause_r <= 1'b0;
            rstp_r <= 1'b0;
        end else begin
            rst_st_r <= rst_st_nxt;
            paused_r <= paused_nxt;
            invert_r <= invert_nxt;
            four_r <= four_nxt;
            upper_r <= upper_nxt;
            sr_r <= sr_nxt;
            sec_ok_r <= sec_ok_nxt;
            quad_ok_r <= quad_ok_nxt;
            wr_ok_r <= wr_ok_nxt;
            prot_r <= prot_nxt;
            pause_r <= pause_nxt;
            rstp_r <= rstp_nxt;
        end
    end

    assign status_two = sr_r;
    assign paused_op_flag = paused_r;
    assign protection_invert = invert_r;
    assign four_line_enable = four_r;
    assign lock_mode_upper = upper_r;
    assign sec_prog_ok = sec_ok_r;
    assign quad_cmd_ok = quad_ok_r;
    assign sr_write_ok = wr_ok_r;
    assign protect_pin_active = prot_r;
    assign pause_pin_active = pause_r;
    assign reset_pin_active = rstp_r;

    // Checks next to the logic they guard
    sequence s_soft_reset;
        cmd_valid && cmd_opcode == OP_RST_EN ##1 cmd_valid && cmd_opcode == OP_RST_DO;
    endsequence

    chk_suspend_sets: assert property (@(posedge ref_clk) disable iff (srst)
        cmd_valid && cmd_opcode == OP_SUSPEND && !soft_rst |=> paused_op_flag)
        else $error("pause flag not set after suspend");
    chk_resume_clears: assert property (@(posedge ref_clk) disable iff (srst)
        cmd_valid && cmd_opcode == OP_RESUME |=> !paused_op_flag)
        else $error("pause flag not cleared by resume");
    // Quad opcode on the command strobe
    sequence s_quad_cmd;
        cmd_valid && is_quad_op(cmd_opcode);
    endsequence

    chk_softrst_clears: assert property (@(posedge ref_clk) disable iff (srst)
        s_soft_reset |=> !paused_op_flag
        && (!lock_mode_upper || ($past(lock_mode_lower) && $past(permanent_lock_bit))))
        else $error("soft reset did not clear pause or lockdown");
    // One-time protection must survive a soft reset
    chk_otp_survives: assert property (@(posedge ref_clk) disable iff (srst)
        s_soft_reset ##0 (upper_r && lock_mode_lower && permanent_lock_bit) |=> lock_mode_upper)
        else $error("one-time lock lifted by soft reset");
    chk_quad_gate: assert property (@(posedge ref_clk) disable iff (srst)
        s_quad_cmd |-> quad_cmd_ok == four_line_enable)
        else $error("quad qualifier disagrees with enable");
    chk_reserved_zero: assert property (@(posedge ref_clk) disable iff (srst)
        status_two[BIT_RSVD] == 1'b0 ##0 status_two[BIT_FOUR_LINE] == four_line_enable)
        else $error("reserved bit or enable mismatch");
    chk_lock_sticky: assert property (@(posedge ref_clk) disable iff (srst)
        status_two[BIT_LOCK_LO] |=> status_two[BIT_LOCK_LO])
        else $error("lock flag cleared");
    chk_last_locks: assert property (@(posedge ref_clk) disable iff (srst)
        sec_prog_valid && sec_prog_byte == SEC_LAST_BYTE && sec_prog_index == 2'd1
        |=> ##1 status_two[BIT_LOCK_LO])
        else $error("last byte did not lock register one");
    chk_lockdown_holds: assert property (@(posedge ref_clk) disable iff (srst)
        upper_r && !soft_rst |=> upper_r && !sr_write_ok)
        else $error("lockdown left without reset");
    chk_quad_pins: assert property (@(posedge ref_clk) disable iff (srst)
        four_line_enable |-> !protect_pin_active && !pause_pin_active && !reset_pin_active)
        else $error("pins active with four-line mode");
    chk_mode_zero: assert property (@(posedge ref_clk) disable iff (srst)
        wr_valid && write_permit_latch && !upper_r && !lock_mode_lower && !soft_rst
        |=> four_line_enable == $past(wr_data[BIT_FOUR_LINE]))
        else $error("write refused in software mode");
endmodule : fsr_status_two
`default_nettype wire

// File: tb/fsr_host_model.sv
// Host-side model: issues decoded command, write and program strobes.
// Assumes the bench calls its tasks; all changes land on falling edges.
`timescale 1ns/1ps
`default_nettype none
module fsr_host_model (
    input wire logic ref_clk,
    output logic cmd_valid,
    output logic [7:0] cmd_opcode,
    output logic wr_valid,
    output logic [7:0] wr_data,
    output logic sec_prog_valid,
    output logic [1:0] sec_prog_index,
    output logic [6:0] sec_prog_byte
);
    // Idle strobes at time zero
    initial begin
        cmd_valid = 1'b0;
        cmd_opcode = 8'h00;
        wr_valid = 1'b0;
        wr_data = 8'h00;
        sec_prog_valid = 1'b0;
        sec_prog_index = 2'h0;
        sec_prog_byte = 7'h00;
    end
    // Payload is inverted after a strobe so stale values never look valid
    task automatic cmd(input logic [7:0] op);
        @(negedge ref_clk);
        cmd_valid = 1'b1;
        cmd_opcode = op;
        @(negedge ref_clk);
        cmd_valid = 1'b0;
        cmd_opcode = ~op;
    endtask : cmd
    // Reset enable then reset on the very next pulse
    task automatic soft_reset();
        @(negedge ref_clk);
        cmd_valid = 1'b1;
        cmd_opcode = 8'h66;
        @(negedge ref_clk);
        cmd_opcode = 8'h99;
        @(negedge ref_clk);
        cmd_valid = 1'b0;
        cmd_opcode = 8'h00;
    endtask : soft_reset
    task automatic wr(input logic [7:0] d);
        @(negedge ref_clk);
        wr_valid = 1'b1;
        wr_data = d;
        @(negedge ref_clk);
        wr_valid = 1'b0;
        wr_data = ~d;
    endtask : wr
    // Index stays put: it still names the register being pointed at
    task automatic prog(input logic [1:0] idx, input logic [6:0] b);
        @(negedge ref_clk);
        sec_prog_valid = 1'b1;
        sec_prog_index = idx;
        sec_prog_byte = b;
        @(negedge ref_clk);
        sec_prog_valid = 1'b0;
        sec_prog_byte = ~b;
    endtask : prog
endmodule : fsr_host_model
`default_nettype wire

// File: tb/tb_top.sv
// Self-checking bench for the second flash status register block.
// Assumes the host model drives strobes; the bench drives levels.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin mismatches++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_top
    import fsr_pkg::*;
;
    logic ref_clk, srst, latch, lower, pin_n, sel, perm;
    logic cv, wv, pv, paused, inv, four, upper, sec_ok, quad_ok, wr_ok, p_act, h_act, r_act;
    logic [7:0] op, wd, st;
    logic [1:0] pi;
    logic [6:0] pb;
    int compares = 0;
    int mismatches = 0;
    fsr_host_model host (.ref_clk(ref_clk), .cmd_valid(cv), .cmd_opcode(op), .wr_valid(wv),
        .wr_data(wd), .sec_prog_valid(pv), .sec_prog_index(pi), .sec_prog_byte(pb));
    fsr_status_two uut (.ref_clk(ref_clk), .srst(srst), .cmd_valid(cv), .cmd_opcode(op),
        .wr_valid(wv), .wr_data(wd), .write_permit_latch(latch), .lock_mode_lower(lower),
        .permanent_lock_bit(perm), .protect_pin_n(pin_n), .pause_reset_sel(sel),
        .sec_prog_valid(pv), .sec_prog_index(pi), .sec_prog_byte(pb), .status_two(st),
        .paused_op_flag(paused), .protection_invert(inv), .four_line_enable(four),
        .lock_mode_upper(upper), .sec_prog_ok(sec_ok), .quad_cmd_ok(quad_ok),
        .sr_write_ok(wr_ok), .protect_pin_active(p_act), .pause_pin_active(h_act),
        .reset_pin_active(r_act));
    // 100 ns clock
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    task automatic final_report();
        $display("compares=%0d mismatches=%0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : final_report
    task automatic test_reset();
        @(negedge ref_clk);
        `CHK(st, 8'h00)
        `CHK(p_act, 1'b1)
        `CHK(r_act, 1'b1)
        `CHK(h_act, 1'b0)
        $display("test_reset done");
    endtask : test_reset
    task automatic test_pause();
        host.cmd(OP_SUSPEND);
        `CHK(st[7], 1'b1)
        host.cmd(OP_RESUME);
        `CHK(paused, 1'b0)
        host.cmd(OP_SUSPEND);
        host.soft_reset();
        `CHK(paused, 1'b0)
        host.cmd(OP_SUSPEND);
        srst = 1'b1;
        @(negedge ref_clk);
        srst = 1'b0;
        `CHK(st, 8'h00)
        $display("test_pause done");
    endtask : test_pause
    // Lockdown entered on purpose, then lifted by a soft reset
    task automatic test_write();
        latch = 1'b1;
        @(negedge ref_clk);
        `CHK(wr_ok, 1'b1)
        host.wr(8'hFF);
        `CHK(st, 8'h43)
        `CHK(quad_ok, 1'b1)
        `CHK(p_act | r_act, 1'b0)
        host.cmd(OP_QREAD);
        `CHK(quad_ok, 1'b1)
        @(negedge ref_clk);
        `CHK(wr_ok, 1'b0)
        host.wr(8'h00);
        `CHK(st, 8'h43)
        host.soft_reset();
        `CHK(st, 8'h42)
        latch = 1'b0;
        host.wr(8'h00);
        `CHK(st, 8'h42)
        latch = 1'b1;
        lower = 1'b1;
        pin_n = 1'b0;
        host.wr(8'h00);
        host.wr(8'h40);
        `CHK(st, 8'h00)
        `CHK(quad_ok, 1'b0)
        host.cmd(OP_QPROG);
        `CHK(quad_ok, 1'b0)
        // Pin high in pin mode lets writes through; lockdown, then one-time mode
        pin_n = 1'b1;
        host.wr(8'h41);
        `CHK(st, 8'h41)
        `CHK(inv, 1'b1)
        `CHK(upper, 1'b1)
        `CHK(four, 1'b0)
        host.soft_reset();
        `CHK(st, 8'h40)
        host.wr(8'h41);
        perm = 1'b1;
        host.soft_reset();
        `CHK(st, 8'h41)
        `CHK(wr_ok, 1'b0)
        sel = 1'b0;
        @(negedge ref_clk);
        `CHK(h_act, 1'b1)
        `CHK(r_act, 1'b0)
        `CHK(p_act, 1'b1)
        perm = 1'b0;
        srst = 1'b1;
        @(negedge ref_clk);
        srst = 1'b0;
        `CHK(upper, 1'b0)
        $display("test_write done");
    endtask : test_write
    task automatic test_locks();
        host.prog(2'h1, 7'h7E);
        repeat (2) @(negedge ref_clk);
        `CHK(st[5:3], 3'h0)
        host.prog(2'h1, 7'h7F);
        host.prog(2'h3, 7'h7F);
        repeat (2) @(negedge ref_clk);
        `CHK(st[5:3], 3'h5)
        `CHK(sec_ok, 1'b0)
        host.prog(2'h2, 7'h00);
        @(negedge ref_clk);
        `CHK(sec_ok, 1'b1)
        host.prog(2'h0, 7'h00);
        @(negedge ref_clk);
        `CHK(sec_ok, 1'b0)
        $display("test_locks done");
    endtask : test_locks
    // Reset for 6 cycles, then the scenarios in order
    initial begin
        srst = 1'b1;
        latch = 1'b0;
        lower = 1'b0;
        pin_n = 1'b1;
        sel = 1'b1;
        perm = 1'b0;
        repeat (6) @(negedge ref_clk);
        srst = 1'b0;
        test_reset();
        test_pause();
        test_write();
        test_locks();
        final_report();
    end
    // Run needs under 100 cycles; allow 2000
    initial begin
        #200_000;
        mismatches++;
        final_report();
    end
endmodule : tb_top
`default_nettype wire
